// ### shared/prescale_if.sv
// Link between the timer core and its input clock divider.
`timescale 1ns/1ns
interface prescale_if;
	logic sel;
	logic tick;
	modport ctrl (output sel, input tick);
	modport div (input sel, output tick);
endinterface

// ### shared/supervision_timer_pkg.sv
// Constants and types shared by the supervision timer design files.
package supervision_timer_pkg;
	localparam int          CLK_PERIOD_NS       = 100;
	localparam int          ACCESS_WINDOW_NS    = 6400;
	localparam int          ACCESS_LIMIT_INT    = ACCESS_WINDOW_NS / CLK_PERIOD_NS;
	localparam logic [6:0]  ACCESS_LIMIT        = 7'(ACCESS_LIMIT_INT);
	localparam logic [9:0]  RESET_HOLD_LAST     = 10'h3FF;
	localparam logic [15:0] FIXED_RELOAD        = 16'hFFFC;
	localparam logic [15:0] COUNT_TOP           = 16'hFFFF;
	localparam logic [15:0] RELOAD_RESET        = 16'h0000;
	localparam logic [5:0]  PASSWORD_RESET      = 6'h00;
	// Fixed password field value; arbitrary.
	localparam logic [7:0]  FIXED_PASSWORD      = 8'hA5;
	localparam int          ENDINIT_BIT         = 0;
	localparam int          GUARD_BIT           = 1;
	localparam int          USER_PW_LSB         = 2;
	localparam int          USER_PW_MSB         = 7;
	localparam int          FIXED_PW_LSB        = 8;
	localparam int          FIXED_PW_MSB        = 15;
	localparam int          RELOAD_LSB          = 16;
	localparam int          RELOAD_MSB          = 31;
	localparam logic [13:0] SLOW_DIV_MASK       = 14'h3FFF;
	localparam logic [13:0] FAST_DIV_MASK       = 14'h00FF;

	typedef enum logic [3:0]
	{
		ST_NORMAL  = 4'b0001,
		ST_TIMEOUT = 4'b0010,
		ST_PREWARN = 4'b0100,
		ST_RESET   = 4'b1000
	} wd_state_t;
endpackage

// ### verif/supervision_timer_tb.sv
// Self-checking bench for the password-guarded supervision timer.
`timescale 1ns/1ns
module supervision_timer_tb;
	import supervision_timer_pkg::*;
	logic        clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        wr = 1'h0;
	logic [31:0] wd = 32'h0;
	logic        sel = 1'h0;
	logic        dis = 1'h0;
	logic [15:0] cnt;
	logic        lock;
	logic        nmi;
	logic        wake;
	logic        srst;
	logic        hold;
	int          miscompares = 0;
	int          n_checks = 0;
	logic [15:0] r;
	logic [5:0]  p;
	int          i;

	supervision_timer u_dut (
		.ref_clk_in         (clk),
		.reset_n_in         (reset_n),
		.wr_in              (wr),
		.wr_data_in         (wd),
		.prescale_sel_in    (sel),
		.timeout_disable_in (dis),
		.count_out          (cnt),
		.endinit_out        (lock),
		.nmi_out            (nmi),
		.wake_out           (wake),
		.sys_reset_out      (srst),
		.hold_reset_out     (hold)
	);

	always #50 clk = ~clk;

	function automatic logic [31:0] word(input logic [15:0] rl,
		input logic [5:0] pw, input logic g, input logic l);
		return {rl, FIXED_PASSWORD, pw, g, l};
	endfunction

	function automatic logic pick(input int w);
		return w == 0 ? nmi : (w == 1 ? srst : cnt != r);
	endfunction

	task end_of_test();
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr1(input logic [31:0] d);
		@(posedge clk);
		wr <= 1'h1;
		wd <= d;
		@(posedge clk);
		wr <= 1'h0;
		@(negedge clk);
	endtask

	// Two writes on consecutive edges form one service.
	task svc(input logic [31:0] a, input logic [31:0] b);
		@(posedge clk);
		wr <= 1'h1;
		wd <= a;
		@(posedge clk);
		wd <= b;
		@(posedge clk);
		wr <= 1'h0;
		@(negedge clk);
	endtask

	task wait_ev(input int w, input int lim);
		i = 0;
		while (pick(w) !== 1'h1 && i < lim)
		begin
			@(negedge clk);
			i++;
		end
	endtask

	task period(input int lim, input int exp);
		r = cnt;
		wait_ev(2, lim);
		r = cnt;
		wait_ev(2, lim);
		chk(16'(i), 16'(exp));
	endtask

	// Follows one error from the trap to the end of the reset pulse.
	task err_seq(input logic h, input int lim);
		wait_ev(0, lim);
		chk(16'(nmi), 16'h0001);
		chk(16'(wake), 16'h0001);
		chk(cnt, FIXED_RELOAD);
		chk(16'(srst), 16'h0000);
		wait_ev(1, 1400);
		chk(16'(srst), 16'h0001);
		repeat (4) @(negedge clk);
		chk(16'(hold), 16'h0000);
		// A repeated timer reset turns into the hold where the pulse would end.
		i = 4;
		while (srst === 1'h1 && hold !== 1'h1 && i < 1100)
		begin
			@(negedge clk);
			i++;
		end
		chk(16'(i), 16'h0400);
		chk(16'({srst, hold}), 16'({h, h}));
		if (!h)
			chk(16'(lock), 16'h0000);
	endtask

	task por();
		@(posedge clk);
		reset_n <= 1'h0;
		@(posedge clk);
		reset_n <= 1'h1;
		dis <= 1'h0;
		@(negedge clk);
		chk(16'({srst, hold}), 16'h0000);
	endtask

	initial
	begin
		void'($urandom(32'hFDFC));
		repeat (4) @(posedge clk);
		reset_n <= 1'h1;
		@(negedge clk);
		chk(cnt, FIXED_RELOAD);
		chk(16'({lock, nmi, wake, srst, hold}), 16'h0000);
		r = 16'($urandom()) & 16'h7FFF;
		p = 6'($urandom());
		svc(word(r, 6'h00, 1'h1, 1'h0), word(r, p, 1'h0, 1'h0));
		chk(cnt, FIXED_RELOAD);
		svc(word(r, p, 1'h1, 1'h1), word(r, p, 1'h0, 1'h1));
		chk(cnt, r);
		chk(16'(lock), 16'h0001);
		period(300, 256);
		@(posedge clk);
		sel <= 1'h1;
		period(16500, 16384);
		@(posedge clk);
		sel <= 1'h0;
		dis <= 1'h1;
		svc(word(16'hFFFE, p, 1'h1, 1'h1), word(16'hFFFE, p, 1'h0, 1'h1));
		wait_ev(0, 1200);
		chk(16'(nmi), 16'h0000);
		chk(16'(cnt[15:1]), 16'h7FFF);
		wr1(word(r, ~p, 1'h1, 1'h1));
		err_seq(1'h0, 4);
		err_seq(1'h1, 1400);
		por();
		svc(word(r, 6'h00, 1'h1, 1'h1), word(r, 6'h00, 1'h1, 1'h1));
		err_seq(1'h0, 4);
		wr1(word(r, 6'h00, 1'h1, 1'h1));
		repeat (70) @(negedge clk);
		wr1(word(r, 6'h00, 1'h0, 1'h1));
		err_seq(1'h1, 4);
		por();
		svc(word(16'hFFFE, 6'h00, 1'h1, 1'h1),
			word(16'hFFFE, 6'h00, 1'h0, 1'h1));
		err_seq(1'h0, 800);
		// Right user password but a wrong fixed field is still an access error.
		wr1(word(r, 6'h00, 1'h1, 1'h1) ^ 32'h0000_0100);
		err_seq(1'h1, 4);
		end_of_test();
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule

// ### verilog/supervision_prescaler.sv
// Free-running divider giving one tick per 256 or 16384 clocks.
`timescale 1ns/1ns
module supervision_prescaler
	import supervision_timer_pkg::*;
(
	input  wire logic ref_clk_in,
	input  wire logic reset_n_in,
	prescale_if.div   pre
);
	logic [13:0] div;
	logic [13:0] next_div;
	logic        tick;
	logic        next_tick;

	always_comb
	begin
		next_div  = div + 14'h0001;
		next_tick = pre.sel ? ((div & SLOW_DIV_MASK) == SLOW_DIV_MASK)
		                    : ((div & FAST_DIV_MASK) == FAST_DIV_MASK);
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			div  <= 14'h0000;
			tick <= 1'b0;
		end
		else
		begin
			div  <= next_div;
			tick <= next_tick;
		end
	end

	assign pre.tick = tick;

	property p_tick_gap;
		@(posedge ref_clk_in) disable iff (!reset_n_in)
		tick |=> !tick [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) // RULE1
		else $error("Divider tick repeated too soon.");
endmodule

// ### verilog/supervision_timer.sv
// Password-guarded supervision timer with pre-warning and lock bit.
//
// Contract
// RULE1: 16-bit counter ticks at clock/256 or /16384, reloads user value.
// RULE2: Time-out and pre-warning modes reload a fixed constant instead.
// RULE3: Writes must carry correct fixed and user password fields; the code checks only the fixed field on the second write.
// RULE4: Service takes two writes; second must come within a limited gap.
// RULE5: Wrong password on first write or bad guard on second starts reset.
// RULE6: Counter overflow before service starts reset.
// RULE7: Timeout may be disabled; password and lock checking stay active.
// RULE8: A second timer reset holds the system in reset until power-on.
// RULE9: The block holds the lock bit and checks every change to it.
// RULE10: The trap raised on error also wakes the system to run mode.
// RULE11: An error raises the trap first, system reset comes later.
// RULE12: The lock bit state drives a system-wide protection line.
// RULE13: A valid full service restarts the counter from its reload.
`timescale 1ns/1ns
module supervision_timer
	import supervision_timer_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        wr_in,
	input  wire logic [31:0] wr_data_in,
	input  wire logic        prescale_sel_in,
	input  wire logic        timeout_disable_in,
	output logic      [15:0] count_out,
	output logic             endinit_out,
	output logic             nmi_out,
	output logic             wake_out,
	output logic             sys_reset_out,
	output logic             hold_reset_out
);
	prescale_if pre ();

	wd_state_t   state;
	wd_state_t   next_state;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [15:0] reload;
	logic [15:0] next_reload;
	logic [5:0]  password;
	logic [5:0]  next_password;
	logic        endinit;
	logic        next_endinit;
	logic        armed;
	logic        next_armed;
	logic [6:0]  win_cnt;
	logic [6:0]  next_win_cnt;
	logic [9:0]  rst_cnt;
	logic [9:0]  next_rst_cnt;
	logic        reset_seen;
	logic        next_reset_seen;
	logic        nmi;
	logic        next_nmi;
	logic        wake;
	logic        next_wake;
	logic        sys_reset;
	logic        next_sys_reset;
	logic        hold;
	logic        next_hold;
	logic        fixed_ok;
	logic        first_ok;
	logic        second_ok;
	logic        err;

	assign pre.sel = prescale_sel_in;

	supervision_prescaler u_prescaler
	(
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.pre        (pre.div)
	);

	always_comb
	begin
		fixed_ok  = wr_data_in[FIXED_PW_MSB:FIXED_PW_LSB] == FIXED_PASSWORD;
		first_ok  = fixed_ok && wr_data_in[GUARD_BIT] // RULE3
		            && wr_data_in[USER_PW_MSB:USER_PW_LSB] == password;
		second_ok = fixed_ok && !wr_data_in[GUARD_BIT];
	end

	always_comb
	begin
		next_state      = state;
		next_count      = count;
		next_reload     = reload;
		next_password   = password;
		next_endinit    = endinit;
		next_armed      = armed;
		next_win_cnt    = armed ? win_cnt + 7'h01 : 7'h00;
		next_rst_cnt    = rst_cnt;
		next_reset_seen = reset_seen;
		next_nmi        = 1'b0;
		next_wake       = 1'b0;
		next_sys_reset  = sys_reset;
		next_hold       = hold;
		err             = 1'b0;
		unique case (state)
			ST_NORMAL, ST_TIMEOUT:
			begin
				if (pre.tick)
				begin
					if (count != COUNT_TOP)
						next_count = count + 16'h0001; // RULE1
					else if (state == ST_TIMEOUT || !timeout_disable_in)
						err = 1'b1; // RULE6
					else
						next_count = reload; // RULE7
				end
				if (wr_in && !armed)
				begin
					if (first_ok)
						next_armed = 1'b1; // RULE4
					else
						err = 1'b1; // RULE5
				end
				else if (wr_in)
				begin
					next_armed = 1'b0;
					if (second_ok)
					begin
						next_endinit  = wr_data_in[ENDINIT_BIT]; // RULE9
						next_password = wr_data_in[USER_PW_MSB:USER_PW_LSB];
						next_reload   = wr_data_in[RELOAD_MSB:RELOAD_LSB];
						if (wr_data_in[ENDINIT_BIT])
						begin
							next_state = ST_NORMAL;
							next_count = wr_data_in[RELOAD_MSB:RELOAD_LSB]; // RULE13
						end
						else
						begin
							next_state = ST_TIMEOUT;
							next_count = FIXED_RELOAD; // RULE2
						end
					end
					else
						err = 1'b1; // RULE5
				end
				else if (armed && win_cnt == ACCESS_LIMIT)
					next_armed = 1'b0; // RULE4
				if (err)
				begin
					next_state = ST_PREWARN; // RULE11
					next_count = FIXED_RELOAD; // RULE2
					next_armed = 1'b0;
					next_nmi   = 1'b1;
					next_wake  = 1'b1; // RULE10
				end
			end
			ST_PREWARN:
			begin
				if (pre.tick && count == COUNT_TOP)
				begin
					next_state     = ST_RESET;
					next_sys_reset = 1'b1; // RULE11
					next_rst_cnt   = 10'h000;
				end
				else if (pre.tick)
					next_count = count + 16'h0001;
			end
			ST_RESET:
			begin
				if (!hold && rst_cnt == RESET_HOLD_LAST)
				begin
					if (reset_seen)
						next_hold = 1'b1; // RULE8
					else
					begin
						next_reset_seen = 1'b1;
						next_sys_reset  = 1'b0;
						next_state      = ST_TIMEOUT;
						next_endinit    = 1'b0;
						next_count      = FIXED_RELOAD;
					end
				end
				else if (!hold)
					next_rst_cnt = rst_cnt + 10'h001;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state      <= ST_TIMEOUT;
			count      <= FIXED_RELOAD;
			reload     <= RELOAD_RESET;
			password   <= PASSWORD_RESET;
			endinit    <= 1'b0;
			armed      <= 1'b0;
			win_cnt    <= 7'h00;
			rst_cnt    <= 10'h000;
			reset_seen <= 1'b0;
			nmi        <= 1'b0;
			wake       <= 1'b0;
			sys_reset  <= 1'b0;
			hold       <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			count      <= next_count;
			reload     <= next_reload;
			password   <= next_password;
			endinit    <= next_endinit;
			armed      <= next_armed;
			win_cnt    <= next_win_cnt;
			rst_cnt    <= next_rst_cnt;
			reset_seen <= next_reset_seen;
			nmi        <= next_nmi;
			wake       <= next_wake;
			sys_reset  <= next_sys_reset;
			hold       <= next_hold;
		end
	end

	assign count_out      = count;
	assign endinit_out    = endinit; // RULE12
	assign nmi_out        = nmi;
	assign wake_out       = wake;
	assign sys_reset_out  = sys_reset;
	assign hold_reset_out = hold;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	property p_overflow;
		state == ST_NORMAL && pre.tick && count == COUNT_TOP
		&& !timeout_disable_in |=> state == ST_PREWARN;
	endproperty
	a_overflow: assert property (p_overflow) // RULE6
		else $error("Overflow did not raise pre-warning.");

	property p_trap;
		$rose(state == ST_PREWARN) |-> nmi_out && !sys_reset_out;
	endproperty
	a_trap: assert property (p_trap) // RULE11
		else $error("Trap missing or reset early on error.");

	property p_wake;
		nmi_out |-> wake_out;
	endproperty
	a_wake: assert property (p_wake) // RULE10
		else $error("Trap did not wake the system.");

	property p_fixed_reload;
		$rose(state == ST_PREWARN) |-> count_out == FIXED_RELOAD;
	endproperty
	a_fixed_reload: assert property (p_fixed_reload) // RULE2
		else $error("Pre-warning did not load the fixed value.");

	property p_bad_first;
		(state == ST_NORMAL || state == ST_TIMEOUT) && wr_in && !armed
		&& !first_ok |=> state == ST_PREWARN;
	endproperty
	a_bad_first: assert property (p_bad_first) // RULE5
		else $error("Bad password did not raise an error.");

	property p_service;
		(state == ST_NORMAL || state == ST_TIMEOUT) && wr_in && armed
		&& second_ok && wr_data_in[ENDINIT_BIT] && !pre.tick
		|=> count_out == $past(wr_data_in[RELOAD_MSB:RELOAD_LSB])
		&& endinit_out && state == ST_NORMAL;
	endproperty
	a_service: assert property (p_service) // RULE13
		else $error("Service did not restart from reload.");

	property p_hold;
		hold_reset_out |=> hold_reset_out && sys_reset_out;
	endproperty
	a_hold: assert property (p_hold) // RULE8
		else $error("Held reset was released.");

	property p_window;
		armed && !wr_in && win_cnt == ACCESS_LIMIT |=> !armed;
	endproperty
	a_window: assert property (p_window) // RULE4
		else $error("Access window did not close.");

	property p_disabled;
		state == ST_NORMAL && timeout_disable_in && pre.tick && !wr_in
		&& count == COUNT_TOP |=> state == ST_NORMAL && !nmi_out;
	endproperty
	a_disabled: assert property (p_disabled) // RULE7
		else $error("Disabled timer still raised an error.");

	property p_reset_len;
		$rose(sys_reset_out) |-> sys_reset_out [*8];
	endproperty
	a_reset_len: assert property (p_reset_len) // RULE11
		else $error("System reset pulse too short.");
endmodule
